//--- bench/pci_pin_model.sv
// partner model: six pins seen through both input buffers
`timescale 1ns/1ps
`default_nettype none
module pci_pin_model #(
  parameter int N = 6
) (
  input  wire logic [N-1:0] level,      // true pin level
  input  wire logic [N-1:0] split,      // ttl buffer reads inverse here
  output logic      [N-1:0] pin_ttl,    // ttl buffer output
  output logic      [N-1:0] pin_schmitt // schmitt buffer output
);
  assign pin_schmitt = level;
  assign pin_ttl     = level ^ split;
endmodule
`default_nettype wire

//--- bench/pci_tb_top.sv
// testbench top for the pin change block
`timescale 1ns/1ps
`default_nettype none
module pci_tb_top;
  import pci_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, portb = 1'b0, sleeping = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, v;
  logic [5:0]  lv = 6'h00, sp = 6'h00;
  logic [1:0]  resp;
  wire logic   awready, wready, bvalid, arready, rvalid, change_irq, wake_req, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [5:0]  pin_ttl, pin_schmitt;
  int          n_mismatch = 0, n_tests = 0;
  always #5 aclk = ~aclk;
  pci_pin_model u_pins (.level(lv), .split(sp), .pin_ttl(pin_ttl), .pin_schmitt(pin_schmitt));
  pci_top DUT (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .pin_ttl(pin_ttl),
    .pin_schmitt(pin_schmitt), .port_b_change(portb), .sleeping(sleeping),
    .change_irq(change_irq), .wake_req(wake_req), .irq(irq));
  // ================================
  // checking and bus tasks
  task summarize;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task tmo;
    n_mismatch++;
    $display("[FAIL] handshake expected 1 seen 0");
    summarize();
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 50) tmo();
    resp = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 50) tmo();
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, v);
  endtask
  task pin(input logic [5:0] x);
    @(posedge aclk) lv <= x;
    repeat (4) @(posedge aclk);
  endtask
  // ================================
  // scenarios
  task t_reset;
    for (int i = 0; i < 4; i++) rc("edge regs", 8'(4 * i), 32'h0);
    rc("analog", PCI_ADDR_ANALOG, 32'h17);
    rc("unmapped", 8'h30, 32'h0);
    chk("rd resp", PCI_RESP_SLVERR, resp);
    wr(8'h30, 32'hFF);
    chk("wr resp", PCI_RESP_SLVERR, resp);
  endtask
  task t_edges;
    wr(PCI_ADDR_ANALOG, 32'h0);
    wr(PCI_ADDR_RISE, 32'h21);
    chk("wr ok resp", PCI_RESP_OKAY, resp);
    wr(PCI_ADDR_FALL, 32'h09);
    pin(6'h3F);
    rc("rise flags", PCI_ADDR_FLAGS, 32'h21);
    pin(6'h00);
    rc("fall flags", PCI_ADDR_FLAGS, 32'h29);
    chk("irq off", 32'h0, change_irq);
    wr(PCI_ADDR_CTRL, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq on", 32'h1, change_irq);
    rc("summary", PCI_ADDR_CTRL, 32'h05);
    rd(PCI_ADDR_FLAGS);
    wr(PCI_ADDR_FLAGS, v & ~32'h1);
    rc("masked clear", PCI_ADDR_FLAGS, 32'h28);
    wr(PCI_ADDR_FLAGS, 32'h0);
    rc("cleared", PCI_ADDR_CTRL, 32'h01);
    chk("rd ok resp", PCI_RESP_OKAY, resp);
    pin(6'h01);
    wr(PCI_ADDR_FLAGS, 32'h0);
    pin(6'h00);
    rc("both fall", PCI_ADDR_FLAGS, 32'h01);
    wr(PCI_ADDR_FLAGS, 32'h0);
    @(posedge aclk) portb <= 1'b1;
    rc("port b", PCI_ADDR_CTRL, 32'h0D);
    chk("irq port b", 32'h1, change_irq);
    @(posedge aclk) portb <= 1'b0;
  endtask
  task t_irq;
    rc("status", PCI_ADDR_IRQ_STAT, 32'h1);
    wr(PCI_ADDR_IRQ_EN, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq set", 32'h1, irq);
    wr(PCI_ADDR_IRQ_CLR, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq clr", 32'h0, irq);
    rc("clr reads", PCI_ADDR_IRQ_CLR, 32'h0);
  endtask
  task t_wake;
    int n;
    n = 0;
    @(posedge aclk) sleeping <= 1'b1;
    @(posedge aclk) lv <= 6'h20;
    repeat (10) @(posedge aclk) n += int'(wake_req === 1'b1);
    chk("wake pulses", 32'd1, 32'(n));
    rc("sleep flags", PCI_ADDR_FLAGS, 32'h20);
    rc("status", PCI_ADDR_IRQ_STAT, 32'h3);
    chk("irq wake", 32'h1, irq);
    @(posedge aclk) sleeping <= 1'b0;
    wr(PCI_ADDR_IRQ_CLR, 32'h3);
    wr(PCI_ADDR_RISE, 32'h0);
    wr(PCI_ADDR_FALL, 32'h0);
  endtask
  task t_level;
    @(posedge aclk) sp <= 6'h02;
    rc("ttl read", PCI_ADDR_PINS, 32'h22);
    wr(PCI_ADDR_THRESH, 32'h02);
    rc("schmitt read", PCI_ADDR_PINS, 32'h20);
    wr(PCI_ADDR_ANALOG, 32'h04);
    wr(PCI_ADDR_RISE, 32'h04);
    wr(PCI_ADDR_FLAGS, 32'h0);
    pin(6'h24);
    rc("analog read", PCI_ADDR_PINS, 32'h20);
    rc("analog flag", PCI_ADDR_FLAGS, 32'h0);
  endtask
  task t_rst2;
    wr(PCI_ADDR_FLAGS, 32'h3F);
    @(posedge aclk) aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc("rst rise", PCI_ADDR_RISE, 32'h0);
    rc("rst flags", PCI_ADDR_FLAGS, 32'h0);
    rc("rst analog", PCI_ADDR_ANALOG, 32'h17);
    chk("rst irq", 32'h0, 32'(change_irq));
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_edges();
    t_irq();
    t_wake();
    t_level();
    t_rst2();
    summarize();
  end
endmodule
bind pci_top pci_top_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_awready(s_awready),
  .s_wready(s_wready), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
  .s_arready(s_arready), .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata),
  .sleeping(sleeping), .change_irq(change_irq), .wake_req(wake_req), .irq(irq));
`default_nettype wire

//--- bench/pci_top_chk.sv
// checker: bus and interrupt timing of the pin change block
`timescale 1ns/1ps
`default_nettype none
module pci_top_chk
  import pci_pkg::*;
(
  input wire logic        aclk,       // clock
  input wire logic        aresetn,    // sync reset, low
  input wire logic        s_awready,  // aw ready
  input wire logic        s_wready,   // w ready
  input wire logic        s_bvalid,   // b valid
  input wire logic        s_bready,   // b ready
  input wire logic [1:0]  s_bresp,    // b response
  input wire logic        s_arready,  // ar ready
  input wire logic        s_rvalid,   // r valid
  input wire logic        s_rready,   // r ready
  input wire logic [31:0] s_rdata,    // r data
  input wire logic        sleeping,   // core asleep
  input wire logic        change_irq, // change request
  input wire logic        wake_req,   // wake pulse
  input wire logic        irq         // bus interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst;
    disable iff (1'b0) !aresetn |=> !change_irq && !wake_req && !irq && !s_bvalid && !s_rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_bhold;
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold;
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  property p_awpulse;
    s_awready |=> !s_awready;
  endproperty
  a_awpulse: assert property (p_awpulse) else $error("awready longer than one cycle");
  property p_rlat;
    s_arready |=> s_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read data late");
  property p_wlat;
    s_awready && s_wready |=> !s_bvalid ##1 s_bvalid;
  endproperty
  a_wlat: assert property (p_wlat) else $error("write response timing wrong");
  property p_wake;
    wake_req |-> $past(sleeping);
  endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_wkirq;
    wake_req |=> change_irq;
  endproperty
  a_wkirq: assert property (p_wkirq) else $error("wake without request");
  c_wake: cover property (wake_req);
  c_irq: cover property (irq && change_irq);
  c_err: cover property (s_bvalid && s_bresp == PCI_RESP_SLVERR);
endmodule
`default_nettype wire

//--- verilog/pci_edge_detect.sv
// per-pin input select, synchroniser and edge detector
`timescale 1ns/1ps
`default_nettype none
module pci_edge_detect
  import pci_pkg::*;
#(
  parameter int N = PCI_NPINS
) (
  input  wire logic         aclk,        // system clock
  input  wire logic         aresetn,     // sync reset, active low
  input  wire logic [N-1:0] pin_ttl,     // ttl-level input buffers
  input  wire logic [N-1:0] pin_schmitt, // schmitt input buffers
  input  wire logic [N-1:0] thresh_sel,  // 1 schmitt, 0 ttl
  input  wire logic [N-1:0] analog_sel,  // 1 digital buffer off
  input  wire logic [N-1:0] rise_en,     // rising edge enables
  input  wire logic [N-1:0] fall_en,     // falling edge enables
  output logic      [N-1:0] level,       // synchronised pin level
  output logic      [N-1:0] edge_hit     // enabled edge seen, one cycle
);
  logic [N-1:0] raw;
  logic [N-1:0] sync1;
  logic [N-1:0] prev;

  // ==========================================================
  // input select
  always_comb begin
    raw = (thresh_sel & pin_schmitt) | (~thresh_sel & pin_ttl); // R12
    raw = raw & ~analog_sel; // R15
  end

  // ==========================================================
  // synchroniser and history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      level <= '0;
      prev  <= '0;
    end else begin
      sync1 <= raw; // R16
      level <= sync1;
      prev  <= level;
    end
  end

  // ==========================================================
  // edge compare
  always_comb begin
    edge_hit = (rise_en & level & ~prev)  // R01 R03 R14
             | (fall_en & ~level & prev); // R02 R03 R14
  end
endmodule
`default_nettype wire

//--- verilog/pci_pkg.sv
// package: register map, field layout and reset values for the pin change interrupt block
package pci_pkg;
  localparam int          PCI_NPINS          = 6;
  // register byte addresses
  localparam logic [7:0]  PCI_ADDR_THRESH    = 8'h00;
  localparam logic [7:0]  PCI_ADDR_RISE      = 8'h04;
  localparam logic [7:0]  PCI_ADDR_FALL      = 8'h08;
  localparam logic [7:0]  PCI_ADDR_FLAGS     = 8'h0C;
  localparam logic [7:0]  PCI_ADDR_CTRL      = 8'h10;
  localparam logic [7:0]  PCI_ADDR_ANALOG    = 8'h14;
  localparam logic [7:0]  PCI_ADDR_PINS      = 8'h18;
  localparam logic [7:0]  PCI_ADDR_IRQ_STAT  = 8'h1C;
  localparam logic [7:0]  PCI_ADDR_IRQ_CLR   = 8'h20;
  localparam logic [7:0]  PCI_ADDR_IRQ_EN    = 8'h24;
  // control register fields
  localparam int          PCI_CTRL_MASTER    = 0;
  localparam int          PCI_CTRL_SLEEP     = 1;
  localparam int          PCI_CTRL_SUMMARY   = 2;
  localparam int          PCI_CTRL_PORTB     = 3;
  // reset values
  localparam logic [5:0]  PCI_RST_THRESH     = 6'h00;
  localparam logic [5:0]  PCI_RST_EDGE_EN    = 6'h00;
  localparam logic [5:0]  PCI_RST_FLAGS      = 6'h00;
  localparam logic [5:0]  PCI_RST_ANALOG     = 6'h17;
  // axi responses
  localparam logic [1:0]  PCI_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  PCI_RESP_SLVERR    = 2'h2;
  // irq status bits
  localparam int          PCI_EV_CHANGE      = 0;
  localparam int          PCI_EV_WAKE        = 1;
  localparam int          PCI_NEV            = 2;
endpackage

//--- verilog/pci_top.sv
// pin change interrupt controller with axi4-lite register slave
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R01 - rising-edge detector per pin, active only when its rise enable bit is set
// R02 - falling-edge detector per pin, active only when its fall enable bit is set
// R03 - both enable bits set detects edges of either polarity
// R04 - enabled edge sets the pin change flag, held until software clears
// R05 - interrupt request only when a flag is set and master enable is one
// R06 - master enable off still detects and sets flags, no request
// R07 - summary flag reads as OR of all flags of both ports
// R08 - writing zero clears a flag; a coincident edge leaves it set
// R09 - software clears flags by AND masking known changed bits only
// R10 - enabled edge wakes the device from sleep when master enable set
// R11 - edge during sleep is in the flags before wake-up completes
// R12 - threshold bit one selects schmitt input, zero ttl, for reads and detection
// R13 - flags readable, writable, hardware set, reset to zero
// R14 - zero enable bit disables that polarity; enables reset to zero
// R15 - analog pin disables digital buffer: reads and detection see no level
// R16 - pins synchronised to clock, edges from successive synchronised samples
module pci_top
  import pci_pkg::*;
#(
  parameter int N = PCI_NPINS
) (
  input  wire logic         aclk,          // system clock 100 MHz
  input  wire logic         aresetn,       // sync reset, active low
  input  wire logic [7:0]   s_awaddr,      // write address
  input  wire logic         s_awvalid,     // write address valid
  output logic              s_awready,     // write address ready
  input  wire logic [31:0]  s_wdata,       // write data
  input  wire logic [3:0]   s_wstrb,       // write byte strobes
  input  wire logic         s_wvalid,      // write data valid
  output logic              s_wready,      // write data ready
  output logic [1:0]        s_bresp,       // write response
  output logic              s_bvalid,      // write response valid
  input  wire logic         s_bready,      // write response ready
  input  wire logic [7:0]   s_araddr,      // read address
  input  wire logic         s_arvalid,     // read address valid
  output logic              s_arready,     // read address ready
  output logic [31:0]       s_rdata,       // read data
  output logic [1:0]        s_rresp,       // read response
  output logic              s_rvalid,      // read data valid
  input  wire logic         s_rready,      // read data ready
  input  wire logic [N-1:0] pin_ttl,       // pins through ttl buffers
  input  wire logic [N-1:0] pin_schmitt,   // pins through schmitt buffers
  input  wire logic         port_b_change, // OR of second port flags
  input  wire logic         sleeping,      // core is asleep
  output logic              change_irq,    // change interrupt request
  output logic              wake_req,      // wake-up request, one cycle
  output logic              irq            // bus interrupt, level
);
  logic [N-1:0]       input_threshold_select;
  logic [N-1:0]       rise_detect_enable;
  logic [N-1:0]       fall_detect_enable;
  logic [N-1:0]       pin_change_flags;
  logic [N-1:0]       analog_pin_select;
  logic               change_irq_master_enable;
  logic [PCI_NEV-1:0] irq_status;
  logic [PCI_NEV-1:0] irq_enable;
  logic [N-1:0]       level;
  logic [N-1:0]       edge_hit;
  logic               change_irq_summary;
  logic               aw_held;
  logic               w_held;
  logic [7:0]         aw_addr;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic               wr_fire;
  logic               rd_fire;
  logic [31:0]        next_rdata;
  logic               rd_ok;
  logic               wr_ok;
  logic [PCI_NEV-1:0] events;

  // ==========================================================
  // helpers
  function automatic logic [N-1:0] low_field(input logic [31:0] d);
    return d[N-1:0];
  endfunction

  function automatic logic [31:0] widen(input logic [N-1:0] v);
    return {{(32-N){1'b0}}, v};
  endfunction

  function automatic logic known_addr(input logic [7:0] a);
    case (a)
      PCI_ADDR_THRESH, PCI_ADDR_RISE, PCI_ADDR_FALL, PCI_ADDR_FLAGS,
      PCI_ADDR_CTRL, PCI_ADDR_ANALOG, PCI_ADDR_PINS, PCI_ADDR_IRQ_STAT,
      PCI_ADDR_IRQ_CLR, PCI_ADDR_IRQ_EN: known_addr = 1'b1;
      default: known_addr = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // edge detection
  pci_edge_detect #(
    .N (N)
  ) u_edge (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .pin_ttl     (pin_ttl),
    .pin_schmitt (pin_schmitt),
    .thresh_sel  (input_threshold_select),
    .analog_sel  (analog_pin_select),
    .rise_en     (rise_detect_enable),
    .fall_en     (fall_detect_enable),
    .level       (level),
    .edge_hit    (edge_hit)
  );

  // ==========================================================
  // write channel capture
  assign wr_fire = aw_held && w_held && !s_bvalid;
  assign wr_ok   = known_addr(aw_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      aw_addr   <= 8'h00;
      s_awready <= 1'b0;
    end else begin
      s_awready <= 1'b0;
      if (wr_fire) begin
        aw_held <= 1'b0;
      end else if (s_awvalid && !aw_held && !s_awready) begin
        s_awready <= 1'b1;
      end
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held   <= 1'b0;
      w_data   <= 32'h00000000;
      w_strb   <= 4'h0;
      s_wready <= 1'b0;
    end else begin
      s_wready <= 1'b0;
      if (wr_fire) begin
        w_held <= 1'b0;
      end else if (s_wvalid && !w_held && !s_wready) begin
        s_wready <= 1'b1;
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= PCI_RESP_OKAY;
    end else if (wr_fire) begin
      s_bvalid <= 1'b1;
      s_bresp  <= wr_ok ? PCI_RESP_OKAY : PCI_RESP_SLVERR;
    end else if (s_bvalid && s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_threshold_select   <= PCI_RST_THRESH;
      rise_detect_enable       <= PCI_RST_EDGE_EN; // R14
      fall_detect_enable       <= PCI_RST_EDGE_EN; // R14
      analog_pin_select        <= PCI_RST_ANALOG;
      change_irq_master_enable <= 1'b0;
      irq_enable               <= '0;
    end else if (wr_fire && w_strb[0]) begin
      case (aw_addr)
        PCI_ADDR_THRESH: input_threshold_select <= low_field(w_data);
        PCI_ADDR_RISE:   rise_detect_enable     <= low_field(w_data);
        PCI_ADDR_FALL:   fall_detect_enable     <= low_field(w_data);
        PCI_ADDR_ANALOG: analog_pin_select      <= low_field(w_data);
        PCI_ADDR_CTRL:   change_irq_master_enable <= w_data[PCI_CTRL_MASTER];
        PCI_ADDR_IRQ_EN: irq_enable             <= w_data[PCI_NEV-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // change flags: hardware set wins over software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_change_flags <= PCI_RST_FLAGS; // R13
    end else if (wr_fire && w_strb[0] && aw_addr == PCI_ADDR_FLAGS) begin
      pin_change_flags <= low_field(w_data) | edge_hit; // R08 R13
    end else begin
      pin_change_flags <= pin_change_flags | edge_hit; // R04 R11
    end
  end

  assign change_irq_summary = (|pin_change_flags) | port_b_change; // R07

  // ==========================================================
  // interrupt and wake outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      change_irq <= 1'b0;
      wake_req   <= 1'b0;
    end else begin
      change_irq <= change_irq_summary && change_irq_master_enable; // R05 R06
      wake_req   <= sleeping && change_irq_master_enable && (|edge_hit); // R10
    end
  end

  // ==========================================================
  // event status, clear and enable
  always_comb begin
    events                = '0;
    events[PCI_EV_CHANGE] = |edge_hit;
    events[PCI_EV_WAKE]   = sleeping && change_irq_master_enable && (|edge_hit);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else if (wr_fire && w_strb[0] && aw_addr == PCI_ADDR_IRQ_CLR) begin
      irq_status <= (irq_status & ~w_data[PCI_NEV-1:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // ==========================================================
  // read channel
  assign rd_fire = s_arvalid && s_arready;
  assign rd_ok   = known_addr(s_araddr);

  always_comb begin
    next_rdata = 32'h00000000;
    case (s_araddr)
      PCI_ADDR_THRESH:   next_rdata = widen(input_threshold_select);
      PCI_ADDR_RISE:     next_rdata = widen(rise_detect_enable);
      PCI_ADDR_FALL:     next_rdata = widen(fall_detect_enable);
      PCI_ADDR_FLAGS:    next_rdata = widen(pin_change_flags); // R13
      PCI_ADDR_ANALOG:   next_rdata = widen(analog_pin_select);
      PCI_ADDR_PINS:     next_rdata = widen(level); // R12 R15
      PCI_ADDR_IRQ_STAT: next_rdata[PCI_NEV-1:0] = irq_status;
      PCI_ADDR_IRQ_EN:   next_rdata[PCI_NEV-1:0] = irq_enable;
      PCI_ADDR_CTRL: begin
        next_rdata[PCI_CTRL_MASTER]  = change_irq_master_enable;
        next_rdata[PCI_CTRL_SLEEP]   = sleeping;
        next_rdata[PCI_CTRL_SUMMARY] = change_irq_summary; // R07
        next_rdata[PCI_CTRL_PORTB]   = port_b_change;
      end
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
    end else begin
      s_arready <= s_arvalid && !s_arready && !s_rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h00000000;
      s_rresp  <= PCI_RESP_OKAY;
    end else if (rd_fire) begin
      s_rvalid <= 1'b1;
      s_rdata  <= next_rdata;
      s_rresp  <= rd_ok ? PCI_RESP_OKAY : PCI_RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire
